// >>> core/dcu_justify.sv
`timescale 1ns/1ps
module dcu_justify (
   // Raw bytes and format
   input wire logic [7:0] high_byte,
   input wire logic [7:0] low_byte,
   input wire logic [2:0] justify,
   // Twelve-bit word
   output logic [11:0] word
);
   // Pure shift; low bits below the format are dropped
   always_comb begin
      word = {high_byte[3:0], low_byte}; // RULE6
      if (justify[2]) begin
         word = {high_byte, low_byte[7:4]}; // RULE10 RULE12
      end else begin
         case (justify[1:0])
            2'h0: word = {high_byte[3:0], low_byte}; // RULE6
            2'h1: word = {high_byte[4:0], low_byte[7:1]}; // RULE7 RULE12
            2'h2: word = {high_byte[5:0], low_byte[7:2]}; // RULE8 RULE12
            2'h3: word = {high_byte[6:0], low_byte[7:3]}; // RULE9 RULE12
            default: word = {high_byte[3:0], low_byte};
         endcase
      end
   end
endmodule : dcu_justify

// >>> core/dcu_top.sv
`timescale 1ns/1ps
`include "dcu_regs.svh"
// What this block does
// (RULE1) Enable bit 0 turns the output pin off and holds the converter in shutdown.
// (RULE2) Enable bit 1 drives the output pin and keeps the converter running.
// (RULE3) Control bits 6 and 5 read as zero and ignore writes.
// (RULE4) Source 00 updates the converter when the high data byte is written.
// (RULE5) Source 01, 10, 11 update on timer 3, timer 4, timer 2 overflow.
// (RULE6) Format 000 takes high[3:0] and all of the low byte.
// (RULE7) Format 001 takes high[4:0] and low[7:1].
// (RULE8) Format 010 takes high[5:0] and low[7:2].
// (RULE9) Format 011 takes high[6:0] and low[7:3].
// (RULE10) Format 1xx takes high[7:0] and low[7:4].
// (RULE11) In timer modes written data waits until the chosen overflow.
// (RULE12) Low byte bits below the chosen format never reach the word.
module dcu_top (
   // Clock and reset
   input wire logic CLK,
   input wire logic RESET_N,
   // Register port
   input wire logic [1:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   // Timer overflow strobes, same clock
   input wire logic OVF_TIMER2,
   input wire logic OVF_TIMER3,
   input wire logic OVF_TIMER4,
   // Converter side
   output logic [11:0] CONV_WORD,
   output logic CONV_UPDATE,
   output logic CONV_SHUTDOWN,
   output logic PIN_OE
);
   // ==========================================================
   // Reset release
   // Assert is immediate; release waits two edges so no flop sees it mid-setup
   logic rst_meta;
   logic rst_n;
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ==========================================================
   // Request bundling
   // Port and overflow strobes are on this clock, so no synchroniser here
   dcu_pkg::dcu_req_t req;
   dcu_pkg::dcu_ovf_t ovf;
   assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
   assign ovf = '{timer2: OVF_TIMER2, timer3: OVF_TIMER3, timer4: OVF_TIMER4};

   // ==========================================================
   // Registers
   logic [7:0] control;
   logic [7:0] data_low_byte;
   logic [7:0] data_high_byte;
   logic converter_enable_bit;
   dcu_pkg::dcu_source_t update_source_select;
   logic [2:0] data_justify_select;
   assign converter_enable_bit = control[`DCU_ENABLE_BIT];
   assign update_source_select =
      dcu_pkg::dcu_source_t'(control[`DCU_SOURCE_HI:`DCU_SOURCE_LO]);
   assign data_justify_select = control[`DCU_JUSTIFY_HI:`DCU_JUSTIFY_LO];

   // Control write; unused bits are never stored
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         control <= `DCU_CONTROL_RESET;
      end else if (req.wr && req.addr == `DCU_ADDR_CONTROL) begin
         control <= req.wdata & `DCU_CONTROL_MASK; // RULE3
      end
   end

   // Data bytes are only holding registers until an update
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         data_low_byte <= `DCU_DATA_RESET;
         data_high_byte <= `DCU_DATA_RESET;
      end else if (req.wr) begin
         if (req.addr == `DCU_ADDR_DATA_LOW) begin
            data_low_byte <= req.wdata;
         end
         if (req.addr == `DCU_ADDR_DATA_HIGH) begin
            data_high_byte <= req.wdata;
         end
      end
   end

   // ==========================================================
   // Justification
   // Two copies: stored bytes for timer loads, write-port byte for source 00
   logic [11:0] pending_word;
   logic [11:0] write_word;
   dcu_justify u_pend (
      .high_byte(data_high_byte),
      .low_byte(data_low_byte),
      .justify(data_justify_select),
      .word(pending_word)
   );
   // Word seen with the incoming high byte, so a high-byte write updates at once
   dcu_justify u_wr (
      .high_byte(req.wdata),
      .low_byte(data_low_byte),
      .justify(data_justify_select),
      .word(write_word)
   );

   // ==========================================================
   // Update trigger selection
   // Only one trigger is live at a time; the others are simply ignored
   logic high_write;
   logic next_update;
   assign high_write = req.wr && req.addr == `DCU_ADDR_DATA_HIGH;
   always_comb begin
      case (update_source_select)
         dcu_pkg::DCU_SRC_HIGH_WRITE: next_update = high_write; // RULE4
         dcu_pkg::DCU_SRC_TIMER3: next_update = ovf.timer3; // RULE5
         dcu_pkg::DCU_SRC_TIMER4: next_update = ovf.timer4; // RULE5
         dcu_pkg::DCU_SRC_TIMER2: next_update = ovf.timer2; // RULE5
         default: next_update = 1'b0;
      endcase
   end

   // Converter word only moves on the chosen trigger
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         CONV_WORD <= `DCU_WORD_RESET;
         CONV_UPDATE <= 1'b0;
      end else begin
         CONV_UPDATE <= next_update;
         if (next_update) begin
            if (update_source_select == dcu_pkg::DCU_SRC_HIGH_WRITE) begin
               CONV_WORD <= write_word; // RULE4
            end else begin
               CONV_WORD <= pending_word; // RULE11
            end
         end
      end
   end

   // ==========================================================
   // Power and pin control
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         CONV_SHUTDOWN <= 1'b1;
         PIN_OE <= 1'b0;
      end else begin
         CONV_SHUTDOWN <= !converter_enable_bit; // RULE1 RULE2
         PIN_OE <= converter_enable_bit; // RULE1 RULE2
      end
   end

   // ==========================================================
   // Read port; data one cycle after the strobe
   // Idle cycles read zero so a stale byte never looks like an answer
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         RDATA <= 8'h00;
      end else if (req.rd) begin
         case (req.addr)
            `DCU_ADDR_CONTROL: RDATA <= control & `DCU_CONTROL_MASK; // RULE3
            `DCU_ADDR_DATA_LOW: RDATA <= data_low_byte;
            `DCU_ADDR_DATA_HIGH: RDATA <= data_high_byte;
            `DCU_ADDR_WORD: RDATA <= CONV_WORD[11:4];
            default: RDATA <= 8'h00;
         endcase
      end else begin
         RDATA <= 8'h00;
      end
   end

   // ==========================================================
   // Checks
   // They watch the port pins and the stored registers
   // Read-back of the control register drops bits 6 and 5
   unused_zero_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE3
      (RD && ADDR == `DCU_ADDR_CONTROL) |=> RDATA[6:5] == 2'h0)
      else $error("unused control bits read nonzero");

   // Disable reaches the pin two edges after the write
   shutdown_off_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE1
      (WR && ADDR == `DCU_ADDR_CONTROL && !WDATA[7]) |=> ##1 (CONV_SHUTDOWN && !PIN_OE))
      else $error("converter not shut down after disable");

   // Enable reaches the pin two edges after the write
   enable_on_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE2
      (WR && ADDR == `DCU_ADDR_CONTROL && WDATA[7]) |=> ##1 (!CONV_SHUTDOWN && PIN_OE))
      else $error("converter not enabled");

   // Source 00 loads on the high byte write
   high_write_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE4
      (high_write && control[4:3] == 2'h0) |=> CONV_UPDATE)
      else $error("high byte write did not update");

   // Timer 3 overflow loads in source 01
   timer3_upd_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE5
      (OVF_TIMER3 && control[4:3] == 2'h1) |=> CONV_UPDATE)
      else $error("timer 3 overflow did not update");

   // Word holds between triggers in timer modes
   timer_hold_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE11
      (control[4:3] != 2'h0 && !next_update) |=> $stable(CONV_WORD))
      else $error("word moved without trigger");

   // Timer loads in format 000
   fmt_zero_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE6
      (next_update && control[4:3] != 2'h0 && control[2:0] == 3'h0)
      |=> CONV_WORD == {$past(data_high_byte[3:0]), $past(data_low_byte)})
      else $error("format 000 word wrong");

   // Timer loads in format 1xx
   fmt_wide_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE10
      (next_update && control[4:3] != 2'h0 && control[2])
      |=> CONV_WORD == {$past(data_high_byte), $past(data_low_byte[7:4])})
      else $error("format 1xx word wrong");

   // Timer loads in format 010
   fmt_mid_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE8
      (next_update && control[4:3] != 2'h0 && control[2:0] == 3'h2)
      |=> CONV_WORD == {$past(data_high_byte[5:0]), $past(data_low_byte[7:2])})
      else $error("format 010 word wrong");

   // Timer 4 overflow loads in source 10
   timer4_upd_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE5
      (OVF_TIMER4 && update_source_select == dcu_pkg::DCU_SRC_TIMER4) |=> CONV_UPDATE)
      else $error("timer 4 overflow did not update");

   // Timer 2 overflow loads in source 11
   timer2_upd_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE5
      (OVF_TIMER2 && update_source_select == dcu_pkg::DCU_SRC_TIMER2) |=> CONV_UPDATE)
      else $error("timer 2 overflow did not update");

   // Strobes of the other timers must not load in source 01
   other_timer_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE5
      (update_source_select == dcu_pkg::DCU_SRC_TIMER3 && !OVF_TIMER3) |=> !CONV_UPDATE)
      else $error("unselected overflow updated");

   // Source 00 ignores every overflow strobe
   strobe_ignored_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE4
      (update_source_select == dcu_pkg::DCU_SRC_HIGH_WRITE && !high_write)
      |=> !CONV_UPDATE)
      else $error("update without high byte write");

   // A high byte write alone never loads in a timer mode
   high_ignored_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE11
      (high_write && update_source_select != dcu_pkg::DCU_SRC_HIGH_WRITE
         && !OVF_TIMER2 && !OVF_TIMER3 && !OVF_TIMER4)
      |=> (!CONV_UPDATE && $stable(CONV_WORD)))
      else $error("high byte write loaded in timer mode");

   // Unused control bits are never held, whatever was written
   unused_held_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE3
      (WR && ADDR == `DCU_ADDR_CONTROL) |=> control[6:5] == 2'h0)
      else $error("unused control bits stored");

   // Source 00 takes the high byte straight from the write port
   wr_fmt0_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE6
      (high_write && update_source_select == dcu_pkg::DCU_SRC_HIGH_WRITE
         && data_justify_select == 3'h0)
      |=> CONV_WORD == {$past(WDATA[3:0]), $past(data_low_byte)})
      else $error("format 000 write word wrong");

   // Source 00 in format 001
   wr_fmt1_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE7
      (high_write && update_source_select == dcu_pkg::DCU_SRC_HIGH_WRITE
         && data_justify_select == 3'h1)
      |=> CONV_WORD == {$past(WDATA[4:0]), $past(data_low_byte[7:1])})
      else $error("format 001 write word wrong");

   // Source 00 in format 010
   wr_fmt2_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE8
      (high_write && update_source_select == dcu_pkg::DCU_SRC_HIGH_WRITE
         && data_justify_select == 3'h2)
      |=> CONV_WORD == {$past(WDATA[5:0]), $past(data_low_byte[7:2])})
      else $error("format 010 write word wrong");

   // Source 00 in format 011
   wr_fmt3_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE9
      (high_write && update_source_select == dcu_pkg::DCU_SRC_HIGH_WRITE
         && data_justify_select == 3'h3)
      |=> CONV_WORD == {$past(WDATA[6:0]), $past(data_low_byte[7:3])})
      else $error("format 011 write word wrong");

   // Source 00 in format 1xx
   wr_fmt4_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE10
      (high_write && update_source_select == dcu_pkg::DCU_SRC_HIGH_WRITE
         && data_justify_select[2])
      |=> CONV_WORD == {$past(WDATA), $past(data_low_byte[7:4])})
      else $error("format 1xx write word wrong");

   // In the widest format the low nibble of the low byte is dropped
   low_drop_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE12
      (next_update && data_justify_select[2])
      |=> CONV_WORD[3:0] == $past(data_low_byte[7:4]))
      else $error("dropped low bits reached the word");
endmodule : dcu_top

// >>> inc/dcu_pkg.sv
package dcu_pkg;
   // Update source encodings
   typedef enum logic [1:0] {
      DCU_SRC_HIGH_WRITE = 2'h0,
      DCU_SRC_TIMER3 = 2'h1,
      DCU_SRC_TIMER4 = 2'h2,
      DCU_SRC_TIMER2 = 2'h3
   } dcu_source_t;
   // Register port request
   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } dcu_req_t;
   // Overflow strobes from the timers
   typedef struct packed {
      logic timer2;
      logic timer3;
      logic timer4;
   } dcu_ovf_t;
endpackage : dcu_pkg

// >>> inc/dcu_regs.svh
`ifndef DCU_REGS_SVH
`define DCU_REGS_SVH
// Register word indices on the plain register port
`define DCU_ADDR_CONTROL 2'h0
`define DCU_ADDR_DATA_LOW 2'h1
`define DCU_ADDR_DATA_HIGH 2'h2
`define DCU_ADDR_WORD 2'h3
// Control field positions
`define DCU_ENABLE_BIT 7
`define DCU_SOURCE_HI 4
`define DCU_SOURCE_LO 3
`define DCU_JUSTIFY_HI 2
`define DCU_JUSTIFY_LO 0
// Writable control bits; bits 6 and 5 are not stored
`define DCU_CONTROL_MASK 8'h9f
// Reset values
`define DCU_CONTROL_RESET 8'h00
`define DCU_DATA_RESET 8'h00
`define DCU_WORD_RESET 12'h000
`endif

// >>> sim/tb_dcu_top.sv
`timescale 1ns/1ps
module tb_dcu_top;
   // ==========================================
   // Bench signals
   logic CLK;
   logic RESET_N;
   logic [1:0] ADDR;
   logic [7:0] WDATA;
   logic WR;
   logic RD;
   logic [7:0] RDATA;
   logic OVF_TIMER2;
   logic OVF_TIMER3;
   logic OVF_TIMER4;
   logic [11:0] CONV_WORD;
   logic CONV_UPDATE;
   logic CONV_SHUTDOWN;
   logic PIN_OE;
   int bad_count;
   int tests_run;
   logic [11:0] exp;
   logic [2:0] sel;
   logic [2:0] fmt;

   dcu_top dcu_top_inst (.CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
      .RD(RD), .RDATA(RDATA), .OVF_TIMER2(OVF_TIMER2), .OVF_TIMER3(OVF_TIMER3),
      .OVF_TIMER4(OVF_TIMER4), .CONV_WORD(CONV_WORD), .CONV_UPDATE(CONV_UPDATE),
      .CONV_SHUTDOWN(CONV_SHUTDOWN), .PIN_OE(PIN_OE));

   // ==========================================
   // Helpers
   // Expected word worked out from the two bytes and the format field
   function automatic logic [11:0] exp_word(input logic [7:0] h, input logic [7:0] l,
      input logic [2:0] j);
      case (j)
         3'h0: return {h[3:0], l};
         3'h1: return {h[4:0], l[7:1]};
         3'h2: return {h[5:0], l[7:2]};
         3'h3: return {h[6:0], l[7:3]};
         default: return {h, l[7:4]};
      endcase
   endfunction : exp_word

   task chk_word(input logic [11:0] got, input logic [11:0] want);
      tests_run++;
      if (got !== want) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, want);
      end
   endtask : chk_word

   task chk_byte(input logic [7:0] got, input logic [7:0] want);
      tests_run++;
      if (got !== want) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, want);
      end
   endtask : chk_byte

   task summarize;
      $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : summarize

   // One-cycle write; returns just after the edge that took it
   task wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
      #1;
   endtask : wr

   // Read data stands only in the cycle after the strobe
   task rd(input logic [1:0] a, input logic [7:0] want);
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1;
      chk_byte(RDATA, want);
   endtask : rd

   // Overflow pulses, ordered timer2, timer3, timer4
   task ovf(input logic [2:0] v);
      @(posedge CLK);
      {OVF_TIMER2, OVF_TIMER3, OVF_TIMER4} <= v;
      @(posedge CLK);
      {OVF_TIMER2, OVF_TIMER3, OVF_TIMER4} <= 3'h0;
      #1;
   endtask : ovf

   // ==========================================
   // Clock and watchdog
   initial begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end

   // Cuts a hang short; the sequence needs far fewer cycles
   initial begin
      repeat (5000) @(posedge CLK);
      bad_count++;
      summarize();
   end

   // ==========================================
   // Main sequence
   initial begin
      {RESET_N, ADDR, WDATA, WR, RD, OVF_TIMER2, OVF_TIMER3, OVF_TIMER4} = '0;
      bad_count = 0;
      tests_run = 0;
      repeat (2) @(posedge CLK);
      #1;
      chk_word({10'h0, CONV_SHUTDOWN, PIN_OE}, 12'h002);
      @(posedge CLK);
      RESET_N <= 1'b1;
      repeat (3) @(posedge CLK);
      rd(2'h0, 8'h00);
      // Unused bits must drop out on read-back
      wr(2'h0, 8'hff);
      rd(2'h0, 8'h9f);
      chk_word({10'h0, CONV_SHUTDOWN, PIN_OE}, 12'h001);
      // Every format code, low bits below the format kept nonzero
      for (int j = 0; j < 8; j++) begin
         wr(2'h0, {5'h10, 3'(j)});
         wr(2'h1, 8'hb5);
         exp = exp_word(8'h9a, 8'hb5, 3'(j));
         wr(2'h2, 8'h9a);
         chk_word({11'h0, CONV_UPDATE}, 12'h001);
         chk_word(CONV_WORD, exp);
         rd(2'h3, exp[11:4]);
      end
      ovf(3'h7);
      chk_word({11'h0, CONV_UPDATE}, 12'h000);
      // Each timer mode; wrong strobes and the high write must not load
      for (int m = 1; m < 4; m++) begin
         sel = (m == 1) ? 3'h2 : (m == 2) ? 3'h1 : 3'h4;
         // Formats 000, 010 and 1xx across the three timers
         fmt = 3'(2 * m - 2);
         wr(2'h0, {3'h4, 2'(m), fmt});
         wr(2'h1, 8'h3c + 8'(m));
         wr(2'h2, 8'h71 + 8'(m));
         chk_word({11'h0, CONV_UPDATE}, 12'h000);
         chk_word(CONV_WORD, exp);
         rd(2'h1, 8'h3c + 8'(m));
         rd(2'h2, 8'h71 + 8'(m));
         ovf(~sel);
         chk_word({11'h0, CONV_UPDATE}, 12'h000);
         chk_word(CONV_WORD, exp);
         exp = exp_word(8'h71 + 8'(m), 8'h3c + 8'(m), fmt);
         ovf(sel);
         chk_word({11'h0, CONV_UPDATE}, 12'h001);
         chk_word(CONV_WORD, exp);
      end
      // Word index is read only
      wr(2'h3, 8'h00);
      rd(2'h3, exp[11:4]);
      wr(2'h0, 8'h00);
      repeat (2) @(posedge CLK);
      #1;
      chk_word({10'h0, CONV_SHUTDOWN, PIN_OE}, 12'h002);
      summarize();
   end
endmodule : tb_dcu_top
